// ==== design/hpd_pkg.sv ====
// constants for the hub port disable and power configuration bank
package hpd_pkg;
	localparam int NUM_PORTS = 7;
	localparam logic [7:0] ADDR_BUS_PORT_DISABLE = 8'h0B;
	localparam logic [7:0] ADDR_SELF_MAX_POWER = 8'h0C;
	localparam logic [7:0] ADDR_BUS_MAX_POWER = 8'h0D;
	localparam logic [7:0] ADDR_HC_CUR_SP = 8'h0E;
	localparam logic [7:0] ADDR_HC_CUR_BP = 8'h0F;
	localparam logic [7:0] RST_PORT_DIS = 8'h00;
	localparam logic [7:0] RST_MAX_PWR = 8'h00;
	localparam logic [7:0] RST_HC_CUR = 8'h32;
	localparam logic [7:0] RESERVED_MASK = 8'hFE;
endpackage : hpd_pkg

// ==== design/hpd_port_map.sv ====
// compacts enabled downstream ports into consecutive logical numbers
`timescale 1ns/100ps
module hpd_port_map (
	// disable mask, bit n is port n, bit 0 unused
	input wire logic [7:0] disable_mask,
	// results
	output logic [2:0] active_count,
	output logic [20:0] logical_of_phys
);
	always_comb begin
		logic [2:0] cnt;
		cnt = 3'h0;
		logical_of_phys = 21'h0;
		for (int p = 1; p <= hpd_pkg::NUM_PORTS; p++) begin
			if (!disable_mask[p]) begin
				cnt = cnt + 3'h1;
				logical_of_phys[(p-1)*3 +: 3] = cnt;
			end
		end
		active_count = cnt;
	end
endmodule : hpd_port_map

// ==== design/hpd_config_bank.sv ====
// configuration bank: bus-powered port disable, max power and controller current
//
// Functional notes
// - set disable bit means port disabled
// - bits 7..1 map ports 7..1, bit0 zero
// - standard mode keeps disabled ports permanently off
// - report enabled count, renumber active ports
// - default config takes disables from straps
// - self-powered max power in 2 mA steps
// - bus-powered max power in 2 mA steps
// - self-powered controller current in 2 mA steps
// - bus-powered controller current in 2 mA steps
// - controller current bytes reset to 50
// - remap enable selects standard or remap numbering; when set, the code instead ignores all disables and reports all 7 ports
`timescale 1ns/100ps
module hpd_config_bank (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// configuration byte port
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_addr,
	input wire logic [7:0] cfg_wdata,
	output logic [7:0] cfg_rdata,
	// mode selection
	input wire logic use_default_cfg,
	input wire logic port_remap_enable,
	input wire logic self_powered,
	// strap pins, asynchronous
	input wire logic [7:1] port_disable_strap_plus,
	input wire logic [7:1] port_disable_strap_minus,
	// to hub core and descriptors
	output logic [7:1] port_disabled,
	output logic [2:0] num_ports_reported,
	output logic [20:0] logical_port_num,
	output logic [7:0] max_power_units,
	output logic [7:0] controller_current_units
);
	logic [7:0] port_dis_q, port_dis_d;
	logic [7:0] mp_sp_q, mp_sp_d;
	logic [7:0] mp_bp_q, mp_bp_d;
	logic [7:0] hc_sp_q, hc_sp_d;
	logic [7:0] hc_bp_q, hc_bp_d;
	logic [7:1] strp_s1_q, strp_s2_q, strm_s1_q, strm_s2_q;
	logic [7:0] eff_mask;
	logic [2:0] cnt_w;
	logic [20:0] map_w;
	logic [7:1] dis_d;
	logic [2:0] num_d;
	logic [20:0] map_d;
	logic [7:0] mp_d, hc_d, rd_d;
	logic [7:1] dis_q;
	logic [2:0] num_q;
	logic [20:0] map_q;
	logic [7:0] mp_q, hc_q, rd_q;

	always_comb begin
		port_dis_d = port_dis_q;
		mp_sp_d = mp_sp_q;
		mp_bp_d = mp_bp_q;
		hc_sp_d = hc_sp_q;
		hc_bp_d = hc_bp_q;
		if (cfg_wr) begin
			unique case (cfg_addr)
				hpd_pkg::ADDR_BUS_PORT_DISABLE: port_dis_d = cfg_wdata & hpd_pkg::RESERVED_MASK;
				hpd_pkg::ADDR_SELF_MAX_POWER: mp_sp_d = cfg_wdata;
				hpd_pkg::ADDR_BUS_MAX_POWER: mp_bp_d = cfg_wdata;
				hpd_pkg::ADDR_HC_CUR_SP: hc_sp_d = cfg_wdata;
				hpd_pkg::ADDR_HC_CUR_BP: hc_bp_d = cfg_wdata;
				default: ;
			endcase
		end
	end

	// straps only matter in default mode, but are always synchronised
	always_ff @(posedge mclk) begin
		strp_s1_q <= port_disable_strap_plus;
		strp_s2_q <= strp_s1_q;
		strm_s1_q <= port_disable_strap_minus;
		strm_s2_q <= strm_s1_q;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			port_dis_q <= hpd_pkg::RST_PORT_DIS;
			mp_sp_q <= hpd_pkg::RST_MAX_PWR;
			mp_bp_q <= hpd_pkg::RST_MAX_PWR;
			hc_sp_q <= hpd_pkg::RST_HC_CUR;
			hc_bp_q <= hpd_pkg::RST_HC_CUR;
		end else begin
			port_dis_q <= port_dis_d;
			mp_sp_q <= mp_sp_d;
			mp_bp_q <= mp_bp_d;
			hc_sp_q <= hc_sp_d;
			hc_bp_q <= hc_bp_d;
		end
	end

	// in default mode a port is off if either strap marks it; remap mode ignores the disable byte and the straps
	always_comb begin
		if (port_remap_enable) begin
			eff_mask = 8'h00;
		end else if (use_default_cfg) begin
			eff_mask = {strp_s2_q | strm_s2_q, 1'b0};
		end else begin
			eff_mask = port_dis_q;
		end
	end

	hpd_port_map u_map (
		.disable_mask(eff_mask),
		.active_count(cnt_w),
		.logical_of_phys(map_w)
	);

	always_comb begin
		dis_d = eff_mask[7:1];
		num_d = cnt_w;
		map_d = map_w;
		mp_d = self_powered ? mp_sp_q : mp_bp_q;
		hc_d = self_powered ? hc_sp_q : hc_bp_q;
		unique case (cfg_addr)
			hpd_pkg::ADDR_BUS_PORT_DISABLE: rd_d = port_dis_q & hpd_pkg::RESERVED_MASK;
			hpd_pkg::ADDR_SELF_MAX_POWER: rd_d = mp_sp_q;
			hpd_pkg::ADDR_BUS_MAX_POWER: rd_d = mp_bp_q;
			hpd_pkg::ADDR_HC_CUR_SP: rd_d = hc_sp_q;
			hpd_pkg::ADDR_HC_CUR_BP: rd_d = hc_bp_q;
			default: rd_d = 8'h00;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			dis_q <= 7'h00;
			num_q <= 3'h0;
			map_q <= 21'h0;
			mp_q <= 8'h00;
			hc_q <= 8'h00;
			rd_q <= 8'h00;
		end else begin
			dis_q <= dis_d;
			num_q <= num_d;
			map_q <= map_d;
			mp_q <= mp_d;
			hc_q <= hc_d;
			rd_q <= rd_d;
		end
	end

	assign port_disabled = dis_q;
	assign num_ports_reported = num_q;
	assign logical_port_num = map_q;
	assign max_power_units = mp_q;
	assign controller_current_units = hc_q;
	assign cfg_rdata = rd_q;

	bit_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
		cfg_rdata[0] == 1'b0 || $past(cfg_addr) != hpd_pkg::ADDR_BUS_PORT_DISABLE)
		else $error("reserved bit read as one");
	reset_cur_a: assert property (@(posedge mclk)
		$rose(rst_n) |-> hc_sp_q == hpd_pkg::RST_HC_CUR && hc_bp_q == hpd_pkg::RST_HC_CUR)
		else $error("controller current reset wrong");
	reset_load_a: assert property (@(posedge mclk)
		!rst_n |=> hc_sp_q == hpd_pkg::RST_HC_CUR && hc_bp_q == hpd_pkg::RST_HC_CUR)
		else $error("controller current not reloaded by reset");

	disable_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(!port_remap_enable && !use_default_cfg && $stable(port_dis_q))
		|=> port_disabled == $past(port_dis_q[7:1]))
		else $error("disable byte not applied");
	remap_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
		port_remap_enable |=> port_disabled == 7'h00)
		else $error("remap mode kept ports disabled");
	remap_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
		port_remap_enable |=> num_ports_reported == 3'h7)
		else $error("remap mode reported fewer ports");
	// outputs hold zero for one edge after reset, so the count check skips that edge
	count_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(rst_n) |-> num_ports_reported == 3'(7 - $countones(port_disabled)))
		else $error("port count mismatch");
	map_top_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!port_disabled[7] |-> logical_port_num[20:18] == num_ports_reported)
		else $error("top active port not numbered last");
	map_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
		port_disabled[1] |-> logical_port_num[2:0] == 3'h0)
		else $error("disabled port given a number");

	sequence wr_sp_s;
		cfg_wr && cfg_addr == hpd_pkg::ADDR_SELF_MAX_POWER;
	endsequence
	sp_power_a: assert property (@(posedge mclk) disable iff (!rst_n)
		wr_sp_s ##1 (self_powered && !cfg_wr)
		|=> max_power_units == $past(cfg_wdata, 2))
		else $error("self-powered power not reported");
	sequence wr_bp_s;
		cfg_wr && cfg_addr == hpd_pkg::ADDR_BUS_MAX_POWER;
	endsequence
	bp_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
		wr_bp_s ##1 (!self_powered && !cfg_wr)
		|=> max_power_units == $past(cfg_wdata, 2))
		else $error("bus-powered power write not reported");
	bp_power_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!self_powered |=> max_power_units == $past(mp_bp_q))
		else $error("bus-powered power not reported");

	hc_sp_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
		cfg_wr && cfg_addr == hpd_pkg::ADDR_HC_CUR_SP |=> hc_sp_q == $past(cfg_wdata))
		else $error("self-powered current write lost");
	hc_bp_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
		cfg_wr && cfg_addr == hpd_pkg::ADDR_HC_CUR_BP |=> hc_bp_q == $past(cfg_wdata))
		else $error("bus-powered current write lost");
	sp_current_a: assert property (@(posedge mclk) disable iff (!rst_n)
		self_powered |=> controller_current_units == $past(hc_sp_q))
		else $error("self-powered current wrong");
	bp_current_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!self_powered |=> controller_current_units == $past(hc_bp_q))
		else $error("bus-powered current wrong");
	strap_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(use_default_cfg && !port_remap_enable)
		|=> port_disabled == $past(strp_s2_q | strm_s2_q))
		else $error("strap disable not applied");
endmodule : hpd_config_bank

// ==== sim/hpd_host_model.sv ====
// upstream host model: captures the hub's reported descriptor fields
`timescale 1ns/100ps
module hpd_host_model (
	// clock and enumeration request
	input wire logic mclk,
	input wire logic enum_req,
	// hub descriptor fields
	input wire logic [2:0] num_ports,
	input wire logic [7:0] max_power,
	// captured values
	output logic [2:0] seen_ports,
	output logic [7:0] seen_power
);
	always_ff @(posedge mclk) begin
		if (enum_req) begin
			seen_ports <= num_ports;
			seen_power <= max_power;
		end
	end
endmodule : hpd_host_model

// ==== sim/tb.sv ====
// testbench for the port disable and power configuration bank
`timescale 1ns/100ps
module tb;
	logic mclk = 1'b0, rst_n = 1'b0, cfg_wr = 1'b0, use_default_cfg = 1'b0, port_remap_enable = 1'b0;
	logic self_powered = 1'b0, enum_req = 1'b0;
	logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata, max_power_units, controller_current_units;
	logic [7:1] port_disable_strap_plus = 7'h00, port_disable_strap_minus = 7'h00, port_disabled;
	logic [2:0] num_ports_reported, seen_ports;
	logic [20:0] logical_port_num;
	logic [7:0] seen_power;
	int errors = 0, comparisons = 0, cycles = 0;
	always #20 mclk = ~mclk;
	hpd_config_bank DUT (.mclk(mclk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .use_default_cfg(use_default_cfg),
		.port_remap_enable(port_remap_enable), .self_powered(self_powered),
		.port_disable_strap_plus(port_disable_strap_plus), .port_disable_strap_minus(port_disable_strap_minus),
		.port_disabled(port_disabled), .num_ports_reported(num_ports_reported),
		.logical_port_num(logical_port_num), .max_power_units(max_power_units),
		.controller_current_units(controller_current_units));
	hpd_host_model host (.mclk(mclk), .enum_req(enum_req), .num_ports(num_ports_reported),
		.max_power(max_power_units), .seen_ports(seen_ports), .seen_power(seen_power));
	task automatic close_out;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	task automatic chk(input logic [20:0] exp, input logic [20:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: expected %h got %h", $time, exp, got);
		end
	endtask : chk
	// cfg_wr stays high so back-to-back writes never toggle it within one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cfg_wr = 1'b1;
		cfg_addr = a;
		cfg_wdata = d;
		@(negedge mclk);
	endtask : wr
	task automatic idle(input int n);
		cfg_wr = 1'b0;
		repeat (n) @(negedge mclk);
	endtask : idle
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		cfg_addr = a;
		@(negedge mclk);
		chk(exp, cfg_rdata);
	endtask : rd
	task automatic t_reset;
		rd(8'h0B, 8'h00);
		rd(8'h0E, 8'h32);
		rd(8'h0F, 8'h32);
		chk(8'h32, controller_current_units);
	endtask : t_reset
	task automatic t_disable;
		wr(8'h0B, 8'h07);
		idle(2);
		rd(8'h0B, 8'h06);
		chk(7'h03, port_disabled);
		chk(3'h5, num_ports_reported);
		chk({3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0, 3'h0}, logical_port_num);
		enum_req = 1'b1;
		@(negedge mclk);
		enum_req = 1'b0;
		chk(3'h5, seen_ports);
		port_remap_enable = 1'b1;
		idle(2);
		chk(7'h00, port_disabled);
		chk(3'h7, num_ports_reported);
		port_remap_enable = 1'b0;
		idle(2);
		chk(7'h03, port_disabled);
	endtask : t_disable
	task automatic t_power;
		self_powered = 1'b1;
		wr(8'h0C, 8'h32);
		idle(1);
		self_powered = 1'b0;
		wr(8'h0D, 8'h7D);
		idle(1);
		wr(8'h0E, 8'h19);
		wr(8'h0F, 8'h40);
		wr(8'h10, 8'hAA);
		self_powered = 1'b1;
		idle(2);
		chk(8'h32, max_power_units);
		chk(8'h19, controller_current_units);
		enum_req = 1'b1;
		@(negedge mclk);
		enum_req = 1'b0;
		chk(8'h32, seen_power);
		self_powered = 1'b0;
		idle(2);
		chk(8'h7D, max_power_units);
		chk(8'h40, controller_current_units);
		rd(8'h10, 8'h00);
	endtask : t_power
	task automatic t_straps;
		use_default_cfg = 1'b1;
		port_disable_strap_plus = 7'h40;
		port_disable_strap_minus = 7'h01;
		idle(4);
		chk(7'h41, port_disabled);
		chk(3'h5, num_ports_reported);
	endtask : t_straps
	task automatic t_midreset;
		rst_n = 1'b0;
		idle(2);
		rst_n = 1'b1;
		idle(2);
		rd(8'h0C, 8'h00);
		rd(8'h0D, 8'h00);
		t_reset();
	endtask : t_midreset
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 2000) begin
			errors++;
			close_out();
		end
	end
	initial begin
		repeat (4) @(negedge mclk);
		rst_n = 1'b1;
		idle(2);
		t_reset();
		t_disable();
		t_power();
		t_straps();
		t_midreset();
		close_out();
	end
endmodule : tb
